//--- rtl/fmt_pkg.sv
package fmt_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_FRAME3_RESET_HIGH = 8'h47;
	localparam logic [7:0] ADDR_FRAME3_RESET_LOW = 8'h48;
	localparam logic [7:0] ADDR_AUDIO_FRAME_SYNC = 8'h49;
	localparam logic [7:0] ADDR_AUDIO_FRAME_CLOCK = 8'h4a;
	localparam logic [7:0] ADDR_RESERVED_FIRST = 8'h4b;
	localparam logic [7:0] ADDR_RESERVED_LAST = 8'h50;
	localparam logic [7:0] ADDR_USER_COUNT_MAX_HIGH = 8'h51;
	localparam logic [7:0] ADDR_USER_COUNT_MAX_LOW = 8'h52;
	localparam logic [7:0] ADDR_USER_COUNT_MIN_HIGH = 8'h53;
	localparam logic [7:0] ADDR_USER_COUNT_MIN_LOW = 8'h54;
	localparam logic [7:0] ADDR_USER_REF_DIVIDER_HIGH = 8'h55;
	localparam logic [7:0] ADDR_USER_REF_DIVIDER_LOW = 8'h56;
	localparam logic [7:0] ADDR_USER_FB_DIVIDER_HIGH = 8'h57;
	localparam logic [7:0] ADDR_USER_FB_DIVIDER_LOW = 8'h58;
	localparam logic [7:0] ADDR_USER_PUMP_CURRENT = 8'h59;
	localparam logic [7:0] ADDR_USER_LINES_HIGH = 8'h5a;
	localparam logic [7:0] ADDR_USER_LINES_LOW = 8'h5b;
	localparam logic [7:0] ADDR_USER_AUDIO_FRAME = 8'h5c;
	localparam logic [7:0] ADDR_USER_FORMAT_MISC = 8'h5d;
	localparam int CFG_COUNT = 21;

	// Values after reset
	localparam logic [12:0] FRAME3_RESET_COUNT_RESET = 13'h0001;
	localparam logic [7:0] AUDIO_FRAME_SYNC_RESET = 8'h05;
	localparam logic [7:0] AUDIO_FRAME_CLOCK_RESET = 8'h0b;

	// Fields of the misc register
	localparam int MISC_ENABLE_BIT = 7;
	localparam int MISC_INTERLACE_BIT = 4;
	localparam int MISC_RATE_MSB = 3;

	// Format selection code that picks the user format (value arbitrary)
	localparam logic [3:0] USER_FORMAT_CODE = 4'hf;

	// Frame-rate codes
	localparam logic [3:0] RATE_23_98 = 4'h0;
	localparam logic [3:0] RATE_24 = 4'h1;
	localparam logic [3:0] RATE_25 = 4'h2;
	localparam logic [3:0] RATE_29_97 = 4'h3;
	localparam logic [3:0] RATE_30 = 4'h4;
	localparam logic [3:0] RATE_50 = 4'h5;
	localparam logic [3:0] RATE_59_94 = 4'h6;
	localparam logic [3:0] RATE_60 = 4'h7;

	// Measurement window: reference cycles over this many sync periods
	localparam int REF_CLK_MHZ = 27;
	localparam logic [4:0] WINDOW_PERIODS = 5'h14;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARM = 3'b010,
		ST_COUNT = 3'b100
	} window_state_t;

	function automatic logic [7:0] cfg_mask(input logic [7:0] a);
		case (a)
			ADDR_AUDIO_FRAME_CLOCK: cfg_mask = 8'h0f;
			ADDR_USER_REF_DIVIDER_HIGH: cfg_mask = 8'h03;
			ADDR_USER_FB_DIVIDER_HIGH: cfg_mask = 8'h7f;
			ADDR_USER_LINES_HIGH: cfg_mask = 8'h1f;
			ADDR_USER_FORMAT_MISC: cfg_mask = 8'h9f;
			default: cfg_mask = (a >= ADDR_RESERVED_FIRST &&
				a <= ADDR_RESERVED_LAST) ? 8'h00 : 8'hff;
		endcase
	endfunction

	function automatic logic [7:0] cfg_reset(input logic [7:0] a);
		case (a)
			ADDR_AUDIO_FRAME_SYNC: cfg_reset = AUDIO_FRAME_SYNC_RESET;
			ADDR_AUDIO_FRAME_CLOCK: cfg_reset = AUDIO_FRAME_CLOCK_RESET;
			default: cfg_reset = 8'h00;
		endcase
	endfunction

endpackage

//--- rtl/hsync_window_counter.sv
`timescale 1ns/1ps
module hsync_window_counter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control and events
	input wire logic enable,
	input wire logic hsync_edge,
	input wire logic ref_tick,
	// Result
	output logic [15:0] count_q,
	output logic saturated_q,
	output logic done_q
);

	fmt_pkg::window_state_t state_q;
	logic [4:0] periods_q;
	logic [15:0] run_q;
	logic sat_run_q;
	logic close;

	assign close = (state_q == fmt_pkg::ST_COUNT) && hsync_edge &&
		(periods_q == fmt_pkg::WINDOW_PERIODS - 5'h01);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= fmt_pkg::ST_IDLE;
		end else if (!enable) begin
			state_q <= fmt_pkg::ST_IDLE;
		end else begin
			case (state_q)
				fmt_pkg::ST_IDLE: state_q <= fmt_pkg::ST_ARM;
				fmt_pkg::ST_ARM: begin
					if (hsync_edge) begin
						state_q <= fmt_pkg::ST_COUNT;
					end
				end
				fmt_pkg::ST_COUNT: state_q <= fmt_pkg::ST_COUNT;
				default: state_q <= fmt_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			periods_q <= 5'h00;
			run_q <= 16'h0000;
			sat_run_q <= 1'b0;
		end else if (state_q != fmt_pkg::ST_COUNT || close) begin
			// A new window opens on the closing edge itself
			periods_q <= 5'h00;
			run_q <= {15'h0000, ref_tick};
			sat_run_q <= 1'b0;
		end else begin
			if (hsync_edge) begin
				periods_q <= periods_q + 5'h01;
			end
			if (ref_tick) begin
				if (run_q == 16'hffff) begin
					sat_run_q <= 1'b1;
				end else begin
					run_q <= run_q + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_q <= 16'h0000;
			saturated_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= close;
			if (close) begin
				count_q <= run_q;
				saturated_q <= sat_run_q;
			end
		end
	end

	property p_window_close;
		@(posedge core_clk) disable iff (rst)
		(state_q == fmt_pkg::ST_COUNT && hsync_edge && enable &&
			periods_q == 5'h13) |=> done_q ##1 !done_q;
	endproperty
	a_window_close: assert property (p_window_close)
		else $error("window did not close on the twentieth sync edge");

	property p_done_only_at_close;
		@(posedge core_clk) disable iff (rst)
		done_q |-> $past(periods_q) == 5'h13 && $past(hsync_edge);
	endproperty
	a_done_only_at_close: assert property (p_done_only_at_close)
		else $error("window closed at a wrong period count");

	c_window: cover property (@(posedge core_clk) disable iff (rst) done_q);

endmodule

//--- rtl/user_format_detect_registers.sv
`timescale 1ns/1ps
// Behaviour
// - Third frame-reset count loads from selected format; read-only bits.
// - Count 27 MHz reference cycles over exactly twenty sync periods.
// - Sixteen-bit writable maximum count across two byte registers.
// - Sixteen-bit writable minimum count across two byte registers.
// - Misc bit 7 enables user detection; zero disables it.
// - User format selected: lookup gives stored interlace bit.
// - User format needs observed interlace to match stored bit.
// - User format selected: lookup gives stored four-bit frame-rate code.
// - Codes 0..7 mean 23.98,24,25,29.97,30,50,59.94,60 Hz.
module user_format_detect_registers (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Reference timing
	input wire logic hsync_in,
	input wire logic interlace_in,
	input wire logic ref_tick,
	// Format selection
	input wire logic [3:0] input_format,
	input wire logic table_interlaced,
	input wire logic [3:0] table_frame_rate_code,
	input wire logic [12:0] frame3_format_count,
	// Detection and lookup results
	output logic user_format_detected,
	output logic first_lut_interlaced,
	output logic [3:0] input_frame_rate_code,
	output logic frame_rate_code_valid,
	// User format settings
	output logic user_detect_enable,
	output logic [9:0] user_ref_divider,
	output logic [14:0] user_fb_divider,
	output logic [7:0] user_pump_current,
	output logic [12:0] user_lines_per_frame,
	output logic [7:0] user_audio_frame_setting,
	output logic [7:0] audio_frame_sync_setting,
	output logic [3:0] audio_frame_clock_setting
);

	logic [7:0] cfg_q [fmt_pkg::CFG_COUNT];
	logic [12:0] frame3_count_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic rvalid_q;
	logic hs_meta_q;
	logic hs_sync_q;
	logic hs_prev_q;
	logic il_meta_q;
	logic il_sync_q;
	logic hsync_edge;
	logic [15:0] count_max;
	logic [15:0] count_min;
	logic [15:0] win_count;
	logic win_sat;
	logic win_done;
	logic in_range;
	logic detected_q;
	logic lut_interlaced_q;
	logic [3:0] lut_rate_q;
	logic rate_valid_q;

	function automatic int ix(input logic [7:0] a);
		return int'(a - fmt_pkg::ADDR_AUDIO_FRAME_SYNC);
	endfunction

	// Writable bank, reserved bits masked to zero
	for (genvar g = 0; g < fmt_pkg::CFG_COUNT; g++) begin : g_cfg
		localparam logic [7:0] A = fmt_pkg::ADDR_AUDIO_FRAME_SYNC + 8'(g);
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				cfg_q[g] <= fmt_pkg::cfg_reset(A);
			end else if (reg_wr && reg_addr == A) begin
				cfg_q[g] <= reg_wdata & fmt_pkg::cfg_mask(A);
			end
		end
	end

	assign count_max = {cfg_q[ix(fmt_pkg::ADDR_USER_COUNT_MAX_HIGH)],
		cfg_q[ix(fmt_pkg::ADDR_USER_COUNT_MAX_LOW)]};
	assign count_min = {cfg_q[ix(fmt_pkg::ADDR_USER_COUNT_MIN_HIGH)],
		cfg_q[ix(fmt_pkg::ADDR_USER_COUNT_MIN_LOW)]};

	assign user_detect_enable =
		cfg_q[ix(fmt_pkg::ADDR_USER_FORMAT_MISC)][fmt_pkg::MISC_ENABLE_BIT];
	assign user_ref_divider = {
		cfg_q[ix(fmt_pkg::ADDR_USER_REF_DIVIDER_HIGH)][1:0],
		cfg_q[ix(fmt_pkg::ADDR_USER_REF_DIVIDER_LOW)]};
	assign user_fb_divider = {
		cfg_q[ix(fmt_pkg::ADDR_USER_FB_DIVIDER_HIGH)][6:0],
		cfg_q[ix(fmt_pkg::ADDR_USER_FB_DIVIDER_LOW)]};
	assign user_pump_current = cfg_q[ix(fmt_pkg::ADDR_USER_PUMP_CURRENT)];
	assign user_lines_per_frame = {
		cfg_q[ix(fmt_pkg::ADDR_USER_LINES_HIGH)][4:0],
		cfg_q[ix(fmt_pkg::ADDR_USER_LINES_LOW)]};
	assign user_audio_frame_setting =
		cfg_q[ix(fmt_pkg::ADDR_USER_AUDIO_FRAME)];
	assign audio_frame_sync_setting =
		cfg_q[ix(fmt_pkg::ADDR_AUDIO_FRAME_SYNC)];
	assign audio_frame_clock_setting =
		cfg_q[ix(fmt_pkg::ADDR_AUDIO_FRAME_CLOCK)][3:0];

	// count follows the selected format, never the register port
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			frame3_count_q <= fmt_pkg::FRAME3_RESET_COUNT_RESET;
		end else begin
			frame3_count_q <= frame3_format_count;
		end
	end

	// Read data; reserved and unmapped offsets read zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_addr == fmt_pkg::ADDR_FRAME3_RESET_HIGH) begin
			rdata_d = {3'h0, frame3_count_q[12:8]};
		end else if (reg_addr == fmt_pkg::ADDR_FRAME3_RESET_LOW) begin
			rdata_d = frame3_count_q[7:0];
		end else if (reg_addr >= fmt_pkg::ADDR_AUDIO_FRAME_SYNC &&
			reg_addr <= fmt_pkg::ADDR_USER_FORMAT_MISC) begin
			rdata_d = cfg_q[5'(reg_addr - fmt_pkg::ADDR_AUDIO_FRAME_SYNC)];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

	// Pin synchronisers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hs_meta_q <= 1'b0;
			hs_sync_q <= 1'b0;
			hs_prev_q <= 1'b0;
			il_meta_q <= 1'b0;
			il_sync_q <= 1'b0;
		end else begin
			hs_meta_q <= hsync_in;
			hs_sync_q <= hs_meta_q;
			hs_prev_q <= hs_sync_q;
			il_meta_q <= interlace_in;
			il_sync_q <= il_meta_q;
		end
	end

	assign hsync_edge = hs_sync_q && !hs_prev_q;

	hsync_window_counter u_window (
		.core_clk(core_clk),
		.rst(rst),
		.enable(user_detect_enable),
		.hsync_edge(hsync_edge),
		.ref_tick(ref_tick),
		.count_q(win_count),
		.saturated_q(win_sat),
		.done_q(win_done)
	);

	assign in_range = !win_sat && win_count >= count_min &&
		win_count <= count_max;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			detected_q <= 1'b0;
		end else if (!user_detect_enable) begin
			detected_q <= 1'b0;
		end else if (win_done) begin
			detected_q <= in_range && (il_sync_q ==
				cfg_q[ix(fmt_pkg::ADDR_USER_FORMAT_MISC)]
				[fmt_pkg::MISC_INTERLACE_BIT]);
		end
	end

	assign user_format_detected = detected_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lut_interlaced_q <= 1'b0;
		end else if (input_format == fmt_pkg::USER_FORMAT_CODE) begin
			lut_interlaced_q <= cfg_q[ix(fmt_pkg::ADDR_USER_FORMAT_MISC)]
				[fmt_pkg::MISC_INTERLACE_BIT];
		end else begin
			lut_interlaced_q <= table_interlaced;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lut_rate_q <= fmt_pkg::RATE_23_98;
			rate_valid_q <= 1'b1;
		end else if (input_format == fmt_pkg::USER_FORMAT_CODE) begin
			lut_rate_q <= cfg_q[ix(fmt_pkg::ADDR_USER_FORMAT_MISC)]
				[fmt_pkg::MISC_RATE_MSB:0];
			// only codes up to 60 Hz are defined
			rate_valid_q <= cfg_q[ix(fmt_pkg::ADDR_USER_FORMAT_MISC)]
				[fmt_pkg::MISC_RATE_MSB:0] <= fmt_pkg::RATE_60;
		end else begin
			lut_rate_q <= table_frame_rate_code;
			rate_valid_q <= table_frame_rate_code <= fmt_pkg::RATE_60;
		end
	end

	assign first_lut_interlaced = lut_interlaced_q;
	assign input_frame_rate_code = lut_rate_q;
	assign frame_rate_code_valid = rate_valid_q;

	property p_frame3_read;
		@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == fmt_pkg::ADDR_FRAME3_RESET_LOW) |=>
			reg_rvalid && reg_rdata == $past(frame3_count_q[7:0]);
	endproperty
	a_frame3_read: assert property (p_frame3_read)
		else $error("frame reset count read mismatch");

	property p_frame3_readonly;
		@(posedge core_clk) disable iff (rst)
		(reg_wr && reg_addr == fmt_pkg::ADDR_FRAME3_RESET_LOW) |=>
			frame3_count_q == $past(frame3_format_count);
	endproperty
	a_frame3_readonly: assert property (p_frame3_readonly)
		else $error("frame reset count took a register write");

	property p_above_max;
		@(posedge core_clk) disable iff (rst)
		(win_done && win_count > count_max) |=> !user_format_detected;
	endproperty
	a_above_max: assert property (p_above_max)
		else $error("detected with count above maximum");

	property p_below_min;
		@(posedge core_clk) disable iff (rst)
		(win_done && win_count < count_min) |=> !user_format_detected;
	endproperty
	a_below_min: assert property (p_below_min)
		else $error("detected with count below minimum");

	property p_disabled;
		@(posedge core_clk) disable iff (rst)
		!user_detect_enable |=> !user_format_detected;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("detected while user mode disabled");

	property p_lut_interlace;
		@(posedge core_clk) disable iff (rst)
		(input_format == fmt_pkg::USER_FORMAT_CODE) |=>
			first_lut_interlaced == $past(cfg_q[ix(
			fmt_pkg::ADDR_USER_FORMAT_MISC)][fmt_pkg::MISC_INTERLACE_BIT]);
	endproperty
	a_lut_interlace: assert property (p_lut_interlace)
		else $error("lookup interlace not the user bit");

	property p_interlace_mismatch;
		@(posedge core_clk) disable iff (rst)
		(win_done && il_sync_q != cfg_q[ix(fmt_pkg::ADDR_USER_FORMAT_MISC)]
			[fmt_pkg::MISC_INTERLACE_BIT]) |=> !user_format_detected;
	endproperty
	a_interlace_mismatch: assert property (p_interlace_mismatch)
		else $error("detected with interlace mismatch");

	property p_lut_rate;
		@(posedge core_clk) disable iff (rst)
		(input_format == fmt_pkg::USER_FORMAT_CODE) |=>
			input_frame_rate_code == $past(cfg_q[ix(
			fmt_pkg::ADDR_USER_FORMAT_MISC)][fmt_pkg::MISC_RATE_MSB:0]);
	endproperty
	a_lut_rate: assert property (p_lut_rate)
		else $error("lookup rate code not the user code");

	property p_rate_valid;
		@(posedge core_clk) disable iff (rst)
		frame_rate_code_valid == (input_frame_rate_code <= 4'h7);
	endproperty
	a_rate_valid: assert property (p_rate_valid)
		else $error("rate code validity wrong");

	property p_detect;
		@(posedge core_clk) disable iff (rst)
		(win_done && user_detect_enable && in_range &&
			il_sync_q == cfg_q[ix(fmt_pkg::ADDR_USER_FORMAT_MISC)]
			[fmt_pkg::MISC_INTERLACE_BIT]) |=>
			user_format_detected ##1 (user_format_detected ||
			!$past(user_detect_enable) || $past(win_done));
	endproperty
	a_detect: assert property (p_detect)
		else $error("user format not detected inside window");

	property p_detect_hold;
		@(posedge core_clk) disable iff (rst)
		(!win_done && user_detect_enable) |=>
			$stable(user_format_detected);
	endproperty
	a_detect_hold: assert property (p_detect_hold)
		else $error("detection changed between window closes");

	property p_rvalid_pulse;
		@(posedge core_clk) disable iff (rst)
		reg_rvalid == $past(reg_rd);
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse)
		else $error("read valid not one cycle after read strobe");

	property p_reserved_write;
		@(posedge core_clk) disable iff (rst)
		(reg_wr && reg_addr == fmt_pkg::ADDR_AUDIO_FRAME_CLOCK) |=>
			cfg_q[ix(fmt_pkg::ADDR_AUDIO_FRAME_CLOCK)][7:4] == 4'h0;
	endproperty
	a_reserved_write: assert property (p_reserved_write)
		else $error("reserved bits took a write");

	c_detected: cover property (@(posedge core_clk) disable iff (rst)
		$rose(user_format_detected));
	c_user_lut: cover property (@(posedge core_clk) disable iff (rst)
		input_format == fmt_pkg::USER_FORMAT_CODE);
	c_read_misc: cover property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == fmt_pkg::ADDR_USER_FORMAT_MISC);

endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic core_clk, rst;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_rvalid;
	logic hsync_in, interlace_in, ref_tick, table_interlaced;
	logic [3:0] input_format, table_frame_rate_code;
	logic [12:0] frame3_format_count;
	logic user_format_detected, first_lut_interlaced, frame_rate_code_valid;
	logic [3:0] input_frame_rate_code, audio_frame_clock_setting;
	logic user_detect_enable;
	logic [9:0] user_ref_divider;
	logic [14:0] user_fb_divider;
	logic [7:0] user_pump_current, user_audio_frame_setting;
	logic [7:0] audio_frame_sync_setting;
	logic [12:0] user_lines_per_frame;
	int errors, check_count;
	logic hs_run;
	logic [5:0] k = 6'h00;

	user_format_detect_registers i_dut (
		.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.hsync_in(hsync_in), .interlace_in(interlace_in),
		.ref_tick(ref_tick), .input_format(input_format),
		.table_interlaced(table_interlaced),
		.table_frame_rate_code(table_frame_rate_code),
		.frame3_format_count(frame3_format_count),
		.user_format_detected(user_format_detected),
		.first_lut_interlaced(first_lut_interlaced),
		.input_frame_rate_code(input_frame_rate_code),
		.frame_rate_code_valid(frame_rate_code_valid),
		.user_detect_enable(user_detect_enable),
		.user_ref_divider(user_ref_divider),
		.user_fb_divider(user_fb_divider),
		.user_pump_current(user_pump_current),
		.user_lines_per_frame(user_lines_per_frame),
		.user_audio_frame_setting(user_audio_frame_setting),
		.audio_frame_sync_setting(audio_frame_sync_setting),
		.audio_frame_clock_setting(audio_frame_clock_setting)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Sync source: 60-cycle line, 20 reference ticks kept clear of the edge
	always @(negedge core_clk) begin
		if (hs_run) begin
			k <= (k == 6'h3b) ? 6'h00 : k + 6'h01;
			hsync_in <= (k < 6'h1e);
			ref_tick <= (k >= 6'h0a) && (k < 6'h32) && !k[0];
		end else begin
			hsync_in <= 1'b0;
			ref_tick <= 1'b0;
		end
	end

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk_bit(reg_rvalid, 1'b1);
		chk_val({8'h00, reg_rdata}, {8'h00, exp});
	endtask

	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			8'h47, 8'h48: wmask = 8'h00;
			8'h4a: wmask = 8'h0f;
			8'h55: wmask = 8'h03;
			8'h57: wmask = 8'h7f;
			8'h5a: wmask = 8'h1f;
			8'h5d: wmask = 8'h9f;
			default: wmask = (a >= 8'h4b && a <= 8'h50) ? 8'h00 : 8'hff;
		endcase
	endfunction

	task automatic test_reset_values();
		logic [7:0] e;
		for (int a = 8'h47; a <= 8'h5d; a++) begin
			e = (a == 8'h48) ? 8'h01 : (a == 8'h49) ? 8'h05 :
				(a == 8'h4a) ? 8'h0b : 8'h00;
			reg_check(a[7:0], e);
		end
		chk_bit(user_format_detected, 1'b0);
		chk_bit(frame_rate_code_valid, 1'b1);
		chk_val({12'h000, input_frame_rate_code}, 16'h0000);
	endtask

	task automatic test_write_masks();
		for (int a = 8'h47; a <= 8'h5d; a++)
			reg_write(a[7:0], 8'hff);
		reg_write(8'h60, 8'hff);
		reg_check(8'h47, 8'h00); // read-only count
		for (int a = 8'h49; a <= 8'h5d; a++)
			reg_check(a[7:0], wmask(a[7:0]));
		reg_check(8'h60, 8'h00);
		chk_val({6'h00, user_ref_divider}, 16'h03ff);
		chk_val({1'b0, user_fb_divider}, 16'h7fff);
		chk_val({8'h00, user_pump_current}, 16'h00ff);
		chk_val({3'h0, user_lines_per_frame}, 16'h1fff);
		chk_val({8'h00, user_audio_frame_setting}, 16'h00ff);
		chk_val({8'h00, audio_frame_sync_setting}, 16'h00ff);
		chk_val({12'h000, audio_frame_clock_setting}, 16'h000f);
		chk_bit(user_detect_enable, 1'b1);
		reg_write(8'h5d, 8'h00);
	endtask

	task automatic test_frame3_count();
		frame3_format_count = 13'h1abc;
		repeat (3) @(negedge core_clk);
		reg_check(8'h47, 8'h1a); // high bits follow format
		reg_check(8'h48, 8'hbc); // low bits follow format
		reg_write(8'h48, 8'h00);
		reg_check(8'h48, 8'hbc); // write ignored
	endtask

	task automatic test_lookup();
		input_format = 4'hf;
		for (int c = 0; c < 16; c++) begin
			reg_write(8'h5d, {3'b000, c[0], c[3:0]});
			repeat (2) @(negedge core_clk);
			chk_val({12'h000, input_frame_rate_code}, 16'(c));
			chk_bit(first_lut_interlaced, c[0]);
			chk_bit(frame_rate_code_valid, c < 8);
		end
		input_format = 4'h3;
		table_interlaced = 1'b0;
		table_frame_rate_code = 4'h6;
		repeat (2) @(negedge core_clk);
		chk_bit(first_lut_interlaced, 1'b0); // table path
		chk_val({12'h000, input_frame_rate_code}, 16'h0006);
		input_format = 4'h0;
	endtask

	task automatic detect_case(input logic [15:0] lo, input logic [15:0] hi,
		input logic [7:0] misc, input logic il, input logic exp);
		reg_write(8'h53, lo[15:8]);
		reg_write(8'h54, lo[7:0]);
		reg_write(8'h51, hi[15:8]);
		reg_write(8'h52, hi[7:0]);
		interlace_in = il;
		reg_write(8'h5d, misc);
		repeat (2700) @(negedge core_clk);
		chk_bit(user_format_detected, exp);
	endtask

	// Window holds 20 lines of 20 ticks: 400 counts
	task automatic test_detection();
		hs_run = 1'b1;
		detect_case(16'h0190, 16'h0190, 8'h90, 1'b1, 1'b1);
		detect_case(16'h0191, 16'hffff, 8'h90, 1'b1, 1'b0);
		detect_case(16'h0000, 16'h018f, 8'h90, 1'b1, 1'b0);
		detect_case(16'h0000, 16'hffff, 8'h80, 1'b1, 1'b0);
		detect_case(16'h0000, 16'hffff, 8'h80, 1'b0, 1'b1);
		reg_write(8'h5d, 8'h00);
		repeat (2) @(negedge core_clk);
		chk_bit(user_format_detected, 1'b0); // cleared
		detect_case(16'h0000, 16'hffff, 8'h00, 1'b0, 1'b0);
		hs_run = 1'b0;
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#(20 * 60000);
		errors++;
		print_verdict();
	end

	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		interlace_in = 1'b0;
		input_format = 4'h0;
		table_interlaced = 1'b0;
		table_frame_rate_code = 4'h0;
		frame3_format_count = 13'h0001;
		hs_run = 1'b0;
		errors = 0;
		check_count = 0;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		test_reset_values();
		test_write_masks();
		test_frame3_count();
		test_lookup();
		test_detection();
		print_verdict();
	end
endmodule
